// File: logic/sfc_decode.v
// serial flash command decoder: lock-bit, interface, discovery, general-purpose reads and software reset
// assumes pins arrive asynchronously; the serial clock is oversampled by CLK (100 MHz)
`timescale 1ns/1ps
`include "sfc_map.vh"

// What this block does
// - opcode travels on 1, 2 or 4 lines
// - discovery read: 3-byte address, 8 dummy cycles
// - three-or-four-byte commands follow address mode
// - configurable reads use configured dummy count
// - general-purpose read: always 8 dummy cycles
// - 64 general bytes, then zeros, no wrap
// - write-enable needed before lock write
// - E0h streams sector lock bits, 4-byte address
// - E1h writes one lock byte, 4-byte address
// - 9Bh activates interface; 9Bh/27h runs check
// - reset only on 66h followed by 99h
// - reset starts when select rises after execute
// - reset restores volatile sector locks to zero
// - reset aborts running or suspended writes
// - reset done after flag byte shows bit7
// - arm ignored during status/config writes
// - reset opcodes work in every protocol, rate
module sfc_decode (
  input  wire        CLK,
  input  wire        RST_B,
  input  wire        S_B,
  input  wire        SCK,
  input  wire [3:0]  IO_IN,
  output reg  [3:0]  IO_OUT,
  output reg  [3:0]  IO_OE,
  input  wire [1:0]  PROTO,
  input  wire        DTR,
  input  wire        ADDR4_MODE,
  input  wire [3:0]  CFG_DUMMY,
  input  wire        WRITE_EN_LATCH,
  input  wire        WRITE_BUSY,
  input  wire        CFG_WRITE_BUSY,
  input  wire [7:0]  FLAG_IN,
  input  wire [7:0]  GP_BYTE,
  input  wire [7:0]  ARRAY_BYTE,
  output wire [5:0]  GP_INDEX,
  output wire [31:0] RD_ADDR,
  output reg         SW_RESET,
  output reg         OP_ABORT,
  output reg         RESET_PENDING,
  output reg         AFI_ACTIVE,
  output reg         CRC_GO
);
localparam ST_IDLE  = 7'h01;
localparam ST_OPC   = 7'h02;
localparam ST_ADDR  = 7'h04;
localparam ST_DUMMY = 7'h08;
localparam ST_DIN   = 7'h10;
localparam ST_DOUT  = 7'h20;
localparam ST_SKIP  = 7'h40;
////////////////////////////////////////////////////////////////////////////////
function [3:0] nlines;
  input [1:0] pr;
  case (pr)
    `SFC_PROTO_DUAL: nlines = `SFC_LINES_2;
    `SFC_PROTO_QUAD: nlines = `SFC_LINES_4;
    default:         nlines = `SFC_LINES_1;
  endcase
endfunction
function [7:0] shin;
  input [7:0] sr;
  input [3:0] io;
  input [1:0] pr;
  case (pr)
    `SFC_PROTO_DUAL: shin = {sr[5:0], io[1:0]};
    `SFC_PROTO_QUAD: shin = {sr[3:0], io};
    default:         shin = {sr[6:0], io[0]};
  endcase
endfunction
function [3:0] emit;
  input [7:0] b;
  input [1:0] pr;
  case (pr)
    `SFC_PROTO_DUAL: emit = {2'h0, b[7:6]};
    `SFC_PROTO_QUAD: emit = b[7:4];
    default:         emit = {2'h0, b[7], 1'h0};
  endcase
endfunction
function [3:0] oemask;
  input [1:0] pr;
  case (pr)
    `SFC_PROTO_DUAL: oemask = `SFC_OE_2;
    `SFC_PROTO_QUAD: oemask = `SFC_OE_4;
    default:         oemask = `SFC_OE_1;
  endcase
endfunction
////////////////////////////////////////////////////////////////////////////////
// two flops on every pin; third stage only for edge finding
reg  [2:0]  s_b_sync;
reg  [2:0]  sck_sync;
reg  [3:0]  io_m;
reg  [3:0]  io_s;
always @(posedge CLK or negedge RST_B)
begin
  if (!RST_B)
  begin
    s_b_sync <= 3'h7;
    sck_sync <= 3'h0;
    io_m     <= 4'h0;
    io_s     <= 4'h0;
  end
  else
  begin
    s_b_sync <= {s_b_sync[1:0], S_B};
    sck_sync <= {sck_sync[1:0], SCK};
    io_m     <= IO_IN;
    io_s     <= io_m;
  end
end
wire sel      = ~s_b_sync[1];
wire cs_fall  = s_b_sync[2] & ~s_b_sync[1];
wire cs_rise  = ~s_b_sync[2] & s_b_sync[1];
wire sck_rise = ~sck_sync[2] & sck_sync[1];
wire sck_fall = sck_sync[2] & ~sck_sync[1];
// double rate samples and drives on both edges
wire samp     = sel & (sck_rise | (DTR & sck_fall));
wire adv      = sel & (sck_fall | (DTR & sck_rise));
////////////////////////////////////////////////////////////////////////////////
reg  [6:0]  state;
reg  [7:0]  in_sr;
reg  [3:0]  in_bits;
reg  [2:0]  byte_cnt;
reg  [7:0]  opcode;
reg         opc_done;
reg  [2:0]  addr_len;
reg  [3:0]  dum_len;
reg  [3:0]  dum_cnt;
reg         dir_out;
reg  [31:0] addr;
reg  [7:0]  din_byte;
reg  [4:0]  din_cnt;
reg         crc_mode;
reg  [7:0]  out_sr;
reg  [3:0]  out_cnt;
reg  [6:0]  dout_cnt;
reg         flag_b7;
reg         armed;
reg  [1:0]  vlock [0:`SFC_SECTORS-1];
reg  [7:0]  cur_byte;
integer     i;
wire [3:0]  lines      = nlines(PROTO);
wire [7:0]  next_in    = shin(in_sr, io_s, PROTO);
wire [3:0]  next_bits  = in_bits + lines;
wire        byte_done  = (next_bits == `SFC_BYTE_BITS);
wire [7:0]  src        = (out_cnt == 4'h0) ? cur_byte : out_sr;
wire [3:0]  next_ocnt  = out_cnt + lines;
wire [11:0] sector     = addr[`SFC_SECT_HI:`SFC_SECT_LO];
assign GP_INDEX = dout_cnt[5:0];
assign RD_ADDR  = addr;
always @*
  case (opcode)
    `SFC_OP_LOCK_RD4: cur_byte = {6'h00, vlock[sector]};
    `SFC_OP_FLAG_RD:  cur_byte = FLAG_IN;
    // past the last general byte only zeros, never a wrap
    `SFC_OP_GP_RD:    cur_byte = (dout_cnt < `SFC_GP_BYTES) ? GP_BYTE : 8'h00;
    `SFC_OP_FAST_RD:  cur_byte = ARRAY_BYTE;
    default:          cur_byte = 8'h00;
  endcase
////////////////////////////////////////////////////////////////////////////////
always @(posedge CLK or negedge RST_B)
begin
  if (!RST_B)
  begin
    state         <= ST_IDLE;
    in_sr         <= 8'h00;
    in_bits       <= 4'h0;
    byte_cnt      <= 3'h0;
    opcode        <= 8'h00;
    opc_done      <= 1'b0;
    addr_len      <= 3'h0;
    dum_len       <= 4'h0;
    dum_cnt       <= 4'h0;
    dir_out       <= 1'b0;
    addr          <= 32'h00000000;
    din_byte      <= 8'h00;
    din_cnt       <= 5'h00;
    crc_mode      <= 1'b0;
    out_sr        <= 8'h00;
    out_cnt       <= 4'h0;
    dout_cnt      <= 7'h00;
    flag_b7       <= 1'b0;
    armed         <= 1'b0;
    IO_OUT        <= 4'h0;
    IO_OE         <= 4'h0;
    SW_RESET      <= 1'b0;
    OP_ABORT      <= 1'b0;
    RESET_PENDING <= 1'b0;
    AFI_ACTIVE    <= 1'b0;
    CRC_GO        <= 1'b0;
    for (i = 0; i < `SFC_SECTORS; i = i + 1)
      vlock[i] <= 2'h0;
  end
  else
  begin
    SW_RESET <= 1'b0;
    OP_ABORT <= 1'b0;
    CRC_GO   <= 1'b0;
    if (cs_fall)
    begin
      state    <= ST_OPC;
      in_bits  <= 4'h0;
      byte_cnt <= 3'h0;
      opc_done <= 1'b0;
      dum_cnt  <= 4'h0;
      din_cnt  <= 5'h00;
      crc_mode <= 1'b0;
      out_cnt  <= 4'h0;
      dout_cnt <= 7'h00;
    end
    else if (cs_rise)
    begin
      state  <= ST_IDLE;
      IO_OE  <= 4'h0;
      IO_OUT <= 4'h0;
      if (opc_done)
      begin
        // a select rise ends the command; that is where it takes effect
        armed      <= (opcode == `SFC_OP_RST_ARM) & ~CFG_WRITE_BUSY;
        AFI_ACTIVE <= (opcode == `SFC_OP_AFI);
        CRC_GO     <= crc_mode & ((din_cnt == `SFC_CRC_SHORT) | (din_cnt == `SFC_CRC_LONG));
        if (opcode == `SFC_OP_LOCK_WR4 && WRITE_EN_LATCH && din_cnt == 5'h01 && in_bits == 4'h0)
          vlock[sector] <= din_byte[1:0];
        if (opcode == `SFC_OP_RST_EXEC && armed)
        begin
          SW_RESET      <= 1'b1;
          OP_ABORT      <= WRITE_BUSY;
          RESET_PENDING <= 1'b1;
          for (i = 0; i < `SFC_SECTORS; i = i + 1)
            vlock[i] <= 2'h0;
        end
      end
    end
    else if (samp && (state == ST_OPC || state == ST_ADDR || state == ST_DIN))
    begin
      in_sr   <= next_in;
      in_bits <= byte_done ? 4'h0 : next_bits;
      if (byte_done)
      begin
        case (state)
          ST_OPC:
          begin
            opcode   <= next_in;
            opc_done <= 1'b1;
            dir_out  <= 1'b1;
            dum_len  <= 4'h0;
            case (next_in)
              `SFC_OP_LOCK_RD4, `SFC_OP_LOCK_WR4:
              begin
                addr_len <= `SFC_ADDR_4;
                dir_out  <= (next_in == `SFC_OP_LOCK_RD4);
                state    <= ST_ADDR;
              end
              `SFC_OP_DISC_RD:
              begin
                addr_len <= `SFC_ADDR_3;
                dum_len  <= `SFC_FIXED_DUMMY;
                state    <= ST_ADDR;
              end
              `SFC_OP_FAST_RD:
              begin
                addr_len <= ADDR4_MODE ? `SFC_ADDR_4 : `SFC_ADDR_3;
                dum_len  <= CFG_DUMMY;
                state    <= ST_ADDR;
              end
              `SFC_OP_GP_RD:
              begin
                dum_len <= `SFC_FIXED_DUMMY;
                state   <= ST_DUMMY;
              end
              `SFC_OP_FLAG_RD:
                state <= ST_DOUT;
              `SFC_OP_CRC:
              begin
                crc_mode <= AFI_ACTIVE;
                state    <= AFI_ACTIVE ? ST_DIN : ST_SKIP;
              end
              default:
                state <= ST_SKIP;
            endcase
          end
          ST_ADDR:
          begin
            addr     <= {addr[23:0], next_in};
            byte_cnt <= byte_cnt + 3'h1;
            if (byte_cnt + 3'h1 == addr_len)
              state <= (dum_len != 4'h0) ? ST_DUMMY : (dir_out ? ST_DOUT : ST_DIN);
          end
          default:
          begin
            if (din_cnt == 5'h00)
              din_byte <= next_in;
            if (din_cnt != `SFC_CNT_MAX5)
              din_cnt <= din_cnt + 5'h01;
          end
        endcase
      end
    end
    else if (sel && sck_rise && state == ST_DUMMY)
    begin
      // dummy cycles are whole clock periods, counted on rising edges
      dum_cnt <= dum_cnt + 4'h1;
      if (dum_cnt + 4'h1 == dum_len)
        state <= ST_DOUT;
    end
    else if (adv && state == ST_DOUT)
    begin
      IO_OUT  <= emit(src, PROTO);
      IO_OE   <= oemask(PROTO);
      out_sr  <= src << lines;
      if (out_cnt == 4'h0)
        flag_b7 <= (opcode == `SFC_OP_FLAG_RD) & cur_byte[`SFC_FLAG_READY];
      if (next_ocnt == `SFC_BYTE_BITS)
      begin
        out_cnt <= 4'h0;
        if (dout_cnt != `SFC_CNT_MAX7)
          dout_cnt <= dout_cnt + 7'h01;
        // ready is only seen once the whole flag byte has left
        if ((out_cnt == 4'h0) ? ((opcode == `SFC_OP_FLAG_RD) & cur_byte[`SFC_FLAG_READY]) : flag_b7)
          RESET_PENDING <= 1'b0;
      end
      else
        out_cnt <= next_ocnt;
    end
  end
end

endmodule

// File: logic/sfc_map.vh
// opcodes, line encodings, phase lengths and field positions of the command decoder
// assumes inclusion by sfc_decode.v only
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

`define SFC_OP_RST_ARM     8'h66
`define SFC_OP_RST_EXEC    8'h99
`define SFC_OP_LOCK_RD4    8'hE0
`define SFC_OP_LOCK_WR4    8'hE1
`define SFC_OP_AFI         8'h9B
`define SFC_OP_CRC         8'h27
`define SFC_OP_DISC_RD     8'h5A
`define SFC_OP_GP_RD       8'h96
`define SFC_OP_FAST_RD     8'h0B
`define SFC_OP_FLAG_RD     8'h70

`define SFC_PROTO_SINGLE   2'h0
`define SFC_PROTO_DUAL     2'h1
`define SFC_PROTO_QUAD     2'h2

`define SFC_LINES_1        4'h1
`define SFC_LINES_2        4'h2
`define SFC_LINES_4        4'h4
`define SFC_OE_1           4'h2
`define SFC_OE_2           4'h3
`define SFC_OE_4           4'hF

`define SFC_BYTE_BITS      4'h8
`define SFC_ADDR_3         3'h3
`define SFC_ADDR_4         3'h4
`define SFC_FIXED_DUMMY    4'h8
`define SFC_GP_BYTES       7'h40
`define SFC_CRC_SHORT      5'h0A
`define SFC_CRC_LONG       5'h12
`define SFC_CNT_MAX7       7'h7F
`define SFC_CNT_MAX5       5'h1F
`define SFC_FLAG_READY     7

`define SFC_SECTORS        4096
`define SFC_SECT_HI        27
`define SFC_SECT_LO        16

`endif

// File: testbench/sfc_decode_props.sv
// port assertions for the command decoder
// assumes a bind into sfc_decode; one CLK domain, RST_B async low
`timescale 1ns/1ps
module sfc_decode_props (
  input wire       CLK,
  input wire       RST_B,
  input wire       S_B,
  input wire [1:0] PROTO,
  input wire [3:0] IO_OE,
  input wire [7:0] FLAG_IN,
  input wire       SW_RESET,
  input wire       OP_ABORT,
  input wire       RESET_PENDING,
  input wire       CRC_GO
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////
  sequence s_idle;
    S_B [*6];
  endsequence
  sequence s_pulse;
    SW_RESET ##1 !SW_RESET;
  endsequence
  property p_idle;
    s_idle |-> IO_OE == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("lines driven while idle");
  property p_width;
    IO_OE != 4'h0 |-> IO_OE == (PROTO == 2'h0 ? 4'h2 : PROTO == 2'h1 ? 4'h3 : 4'hF);
  endproperty
  a_width: assert property (p_width) else $error("bad output lines");
  property p_reset;
    SW_RESET |-> S_B && $past(S_B) ##0 s_pulse;
  endproperty
  a_reset: assert property (p_reset) else $error("reset pulse wrong");
  property p_abort;
    OP_ABORT |-> SW_RESET;
  endproperty
  a_abort: assert property (p_abort) else $error("abort without reset");
  property p_set;
    $rose(RESET_PENDING) |-> SW_RESET;
  endproperty
  a_set: assert property (p_set) else $error("pending without reset");
  property p_hold;
    SW_RESET |-> RESET_PENDING;
  endproperty
  a_hold: assert property (p_hold) else $error("reset not pending");
  property p_clr;
    $fell(RESET_PENDING) |-> $past(FLAG_IN[7]);
  endproperty
  a_clr: assert property (p_clr) else $error("pending cleared early");
  property p_crc;
    CRC_GO |-> S_B ##1 !CRC_GO;
  endproperty
  a_crc: assert property (p_crc) else $error("check pulse wrong");
endmodule

bind sfc_decode sfc_decode_props i_props (.CLK(CLK), .RST_B(RST_B), .S_B(S_B), .PROTO(PROTO), .IO_OE(IO_OE),
  .FLAG_IN(FLAG_IN), .SW_RESET(SW_RESET), .OP_ABORT(OP_ABORT), .RESET_PENDING(RESET_PENDING), .CRC_GO(CRC_GO));

// File: testbench/sfc_decode_tb_top.sv
// bench for the command decoder: host model on the link
// assumes sfc_host_model and the bound checker
`timescale 1ns/1ps
module sfc_decode_tb_top;
  reg         CLK, RST_B, DTR, ADDR4_MODE, WRITE_EN_LATCH, WRITE_BUSY, CFG_WRITE_BUSY;
  reg  [1:0]  PROTO;
  reg  [3:0]  CFG_DUMMY;
  reg  [7:0]  FLAG_IN, ARRAY_BYTE, b;
  wire        S_B, SCK, SW_RESET, OP_ABORT, RESET_PENDING, AFI_ACTIVE, CRC_GO;
  wire [3:0]  IO_IN, IO_OUT, IO_OE;
  wire [5:0]  GP_INDEX;
  wire [31:0] RD_ADDR;
  int         errors, cmp_count, n_rst, n_abort, n_crc;
  // stands in for the general-purpose register contents
  wire [7:0]  GP_BYTE = {2'h0, GP_INDEX} ^ 8'hA5;
  sfc_decode i_dut (.CLK(CLK), .RST_B(RST_B), .S_B(S_B), .SCK(SCK), .IO_IN(IO_IN), .IO_OUT(IO_OUT),
    .IO_OE(IO_OE), .PROTO(PROTO), .DTR(DTR), .ADDR4_MODE(ADDR4_MODE), .CFG_DUMMY(CFG_DUMMY),
    .WRITE_EN_LATCH(WRITE_EN_LATCH), .WRITE_BUSY(WRITE_BUSY), .CFG_WRITE_BUSY(CFG_WRITE_BUSY),
    .FLAG_IN(FLAG_IN), .GP_BYTE(GP_BYTE), .ARRAY_BYTE(ARRAY_BYTE), .GP_INDEX(GP_INDEX), .RD_ADDR(RD_ADDR),
    .SW_RESET(SW_RESET), .OP_ABORT(OP_ABORT), .RESET_PENDING(RESET_PENDING), .AFI_ACTIVE(AFI_ACTIVE),
    .CRC_GO(CRC_GO));
  sfc_host_model hm (.CLK(CLK), .PROTO(PROTO), .DTR(DTR), .IO_OUT(IO_OUT), .IO_OE(IO_OE), .S_B(S_B),
    .SCK(SCK), .IO_IN(IO_IN));
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // pulses last one cycle, so count them as they pass
  always @(posedge CLK)
  begin
    n_rst <= n_rst + (SW_RESET === 1'b1);
    n_abort <= n_abort + (OP_ABORT === 1'b1);
    n_crc <= n_crc + (CRC_GO === 1'b1);
  end
  ////////////////////////////////////////
  task automatic check(input string nm, input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmd(input [7:0] op);
    hm.sel();
    hm.wbyte(op);
    hm.desel();
  endtask
  task automatic send(input [31:0] v, input int n);
    repeat (n)
    begin
      hm.wbyte(v[31:24]);
      v = v << 8;
    end
  endtask
  task automatic rd_lock(input [31:0] a, input [7:0] e);
    hm.sel();
    hm.wbyte(8'hE0);
    send(a, 4);
    repeat (2)
    begin
      hm.rd(8 / hm.k, b);
      check("lock", b, e);
    end
    hm.desel();
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
    begin
      PROTO = i == 3 ? 2'h0 : i[1:0];
      DTR = i == 3;
      WRITE_BUSY = i == 1;
      cmd(8'h66);
      cmd(8'h99);
      check("resets", n_rst, i + 1);
      check("aborts", n_abort, i > 0);
      check("pending", RESET_PENDING, 1);
    end
    DTR = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      FLAG_IN = {i[0], 7'h00};
      hm.sel();
      hm.wbyte(8'h70);
      hm.rd(8, b);
      hm.desel();
      check("pending", RESET_PENDING, i == 0);
    end
    cmd(8'h99);
    cmd(8'h66);
    cmd(8'h9B);
    check("afi", AFI_ACTIVE, 1);
    cmd(8'h99);
    CFG_WRITE_BUSY = 1'b1;
    cmd(8'h66);
    CFG_WRITE_BUSY = 1'b0;
    cmd(8'h99);
    check("resets", n_rst, 4);
  endtask
  task automatic t_lock;
    for (int i = 0; i < 2; i++)
    begin
      WRITE_EN_LATCH = i == 0;
      hm.sel();
      hm.wbyte(8'hE1);
      send(32'h000ABCDE + (i << 16), 4);
      hm.wbyte(8'h03);
      hm.desel();
    end
    check("addr", RD_ADDR, 32'h000BBCDE);
    PROTO = 2'h2;
    rd_lock(32'h000A0000, 8'h03);
    rd_lock(32'h000B0000, 8'h00);
    cmd(8'h66);
    cmd(8'h99);
    rd_lock(32'h000A0000, 8'h00);
    PROTO = 2'h0;
  endtask
  task automatic t_read;
    hm.sel();
    hm.wbyte(8'h96);
    hm.rd(8, b);
    for (int i = 0; i < 66; i++)
    begin
      hm.rd(8, b);
      check("gp", b, i < 64 ? i[7:0] ^ 8'hA5 : 8'h00);
    end
    hm.desel();
    for (int i = 0; i < 3; i++)
    begin
      // last pass: three-byte mode with a different dummy count and data
      ADDR4_MODE = i < 2;
      CFG_DUMMY = i == 2 ? 4'h3 : 4'h5;
      ARRAY_BYTE = i == 2 ? 8'hC6 : 8'h3C;
      hm.sel();
      hm.wbyte(i == 0 ? 8'h5A : 8'h0B);
      send(i == 0 ? 32'h12345600 : 32'h89ABCDEF, i == 1 ? 4 : 3);
      hm.rd(i == 0 ? 8 : CFG_DUMMY, b);
      hm.rd(8, b);
      hm.desel();
      check("data", b, i == 0 ? 8'h00 : ARRAY_BYTE);
      check("addr", RD_ADDR[23:0], i == 0 ? 24'h123456 : i == 1 ? 24'hABCDEF : 24'h89ABCD);
    end
  endtask
  task automatic t_crc;
    int n[4] = '{10, 10, 9, 18};
    int e[4] = '{0, 1, 1, 2};
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0)
        cmd(8'h9B);
      hm.sel();
      hm.wbyte(8'h27);
      repeat (n[i]) hm.wbyte(8'hC3);
      hm.desel();
      check("crc", n_crc, e[i]);
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    RST_B = 1'b0;
    PROTO = 2'h0;
    DTR = 1'b0;
    ADDR4_MODE = 1'b0;
    CFG_DUMMY = 4'h5;
    WRITE_EN_LATCH = 1'b0;
    WRITE_BUSY = 1'b0;
    CFG_WRITE_BUSY = 1'b0;
    FLAG_IN = 8'h80;
    ARRAY_BYTE = 8'h3C;
    repeat (16) @(negedge CLK);
    check("oe", IO_OE, 0);
    RST_B = 1'b1;
    repeat (4) @(negedge CLK);
    t_reset();
    t_lock();
    t_read();
    t_crc();
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge CLK);
    errors++;
    summarize();
  end
endmodule

// File: testbench/sfc_host_model.sv
// host controller model: select, serial clock and data lines
// assumes bench CLK at 100 MHz; lines move at CLK falling edges
`timescale 1ns/1ps
module sfc_host_model (
  input  wire       CLK,
  input  wire [1:0] PROTO,
  input  wire       DTR,
  input  wire [3:0] IO_OUT,
  input  wire [3:0] IO_OE,
  output reg        S_B,
  output reg        SCK,
  output wire [3:0] IO_IN
);
  reg  [3:0] hd;
  reg        hoe;
  wire [2:0] k = PROTO == 2'h0 ? 3'h1 : PROTO == 2'h1 ? 3'h2 : 3'h4;
  // released lines show the inverse, never a stale copy
  assign IO_IN = (IO_OE & IO_OUT) | (~IO_OE & (hoe ? hd : ~hd));
  initial
  begin
    S_B = 1'b1;
    SCK = 1'b0;
    hd = 4'h0;
    hoe = 1'b0;
  end
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic sel;
    S_B = 1'b0;
    tick(4);
  endtask
  task automatic desel;
    hoe = 1'b0;
    S_B = 1'b1;
    tick(8);
  endtask
  task automatic wbyte(input [7:0] v);
    hoe = 1'b1;
    repeat (8 / k)
    begin
      hd = v[7:4] >> (4 - k);
      v = v << k;
      tick(DTR ? 4 : 8);
      SCK = ~SCK;
      tick(DTR ? 4 : 8);
      if (!DTR)
        SCK = 1'b0;
    end
  endtask
  task automatic rd(input int n, output [7:0] v);
    hoe = 1'b0;
    repeat (n)
    begin
      tick(8);
      SCK = 1'b1;
      v = (v << k) | (k == 3'h1 ? IO_IN[1] : k == 3'h2 ? IO_IN[1:0] : IO_IN);
      tick(8);
      SCK = 1'b0;
    end
  endtask
endmodule
